// ==== hdl/test_mode_pkg.sv ====
package test_mode_pkg;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_UNPOWERED = 3'h0,
        ST_NORMAL    = 3'h1,
        ST_RUNTIME   = 3'h2,
        ST_NAND_TREE = 3'h3,
        ST_TRISTATE  = 3'h4,
        ST_RESERVED  = 3'h5
    } mode_state_t;

    // ------------------------------------------------------------
    // Sizes and field positions
    // ------------------------------------------------------------
    localparam int NUM_SLOTS        = 2;
    localparam int NAND_CHAIN_LEN   = 33;
    localparam int DIAG_WORD_WIDTH  = 16;
    localparam int DIAG_A_LOWER_POS = 0;
    localparam int DIAG_A_UPPER_POS = 1;
    localparam int DIAG_A_ONE_POS   = 2;
    localparam int DIAG_B_LOWER_POS = 8;
    localparam int DIAG_B_UPPER_POS = 9;
    localparam int DIAG_B_ONE_POS   = 10;

    // ------------------------------------------------------------
    // Power-on levels of the slot outputs
    // ------------------------------------------------------------
    localparam logic POWER_IND_INIT  = 1'h1;
    localparam logic ATTN_IND_INIT   = 1'h1;
    localparam logic BUS_CONN_INIT   = 1'h1;
    localparam logic CLK_CONN_INIT   = 1'h1;
    localparam logic SLOT_RESET_INIT = 1'h0;

endpackage

// ==== hdl/slot_output_ctrl.sv ====
`timescale 1ns/1ps

module slot_output_ctrl (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_init,
    input  wire logic i_load,
    input  wire logic i_runtime,
    input  wire logic i_power_ind,
    input  wire logic i_attn_ind,
    input  wire logic i_bus_conn,
    input  wire logic i_clk_conn,
    input  wire logic i_slot_reset,
    input  wire logic i_power_enable,
    input  wire logic i_main_fault,
    input  wire logic i_aux_fault,
    output logic      o_power_indicator_drive,
    output logic      o_attention_indicator_drive,
    output logic      o_bus_connect_enable,
    output logic      o_clock_connect_enable,
    output logic      o_slot_reset_out
);

    logic power_ind_reg;
    logic power_ind_next;
    logic attn_ind_reg;
    logic attn_ind_next;
    logic bus_conn_reg;
    logic bus_conn_next;
    logic clk_conn_reg;
    logic clk_conn_next;
    logic slot_reset_reg;
    logic slot_reset_next;
    logic pind_out_reg;
    logic pind_out_next;
    logic aind_out_reg;
    logic aind_out_next;

    // ------------------------------------------------------------
    // Latched controls and indicator selection
    // ------------------------------------------------------------
    always_comb begin
        power_ind_next  = power_ind_reg;
        attn_ind_next   = attn_ind_reg;
        bus_conn_next   = bus_conn_reg;
        clk_conn_next   = clk_conn_reg;
        slot_reset_next = slot_reset_reg;
        if (i_init) begin
            power_ind_next  = test_mode_pkg::POWER_IND_INIT;
            attn_ind_next   = test_mode_pkg::ATTN_IND_INIT;
            bus_conn_next   = test_mode_pkg::BUS_CONN_INIT;
            clk_conn_next   = test_mode_pkg::CLK_CONN_INIT;
            slot_reset_next = test_mode_pkg::SLOT_RESET_INIT;
        end else if (i_load) begin
            power_ind_next  = i_power_ind;
            attn_ind_next   = i_attn_ind;
            bus_conn_next   = i_bus_conn;
            clk_conn_next   = i_clk_conn;
            slot_reset_next = i_slot_reset;
        end
        // The mirrored values use the next latched state so both paths share one cycle of delay.
        pind_out_next = i_runtime ? i_power_enable : power_ind_next;
        aind_out_next = i_runtime ? (i_main_fault & i_aux_fault) : attn_ind_next;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            power_ind_reg  <= test_mode_pkg::POWER_IND_INIT;
            attn_ind_reg   <= test_mode_pkg::ATTN_IND_INIT;
            bus_conn_reg   <= test_mode_pkg::BUS_CONN_INIT;
            clk_conn_reg   <= test_mode_pkg::CLK_CONN_INIT;
            slot_reset_reg <= test_mode_pkg::SLOT_RESET_INIT;
            pind_out_reg   <= test_mode_pkg::POWER_IND_INIT;
            aind_out_reg   <= test_mode_pkg::ATTN_IND_INIT;
        end else begin
            power_ind_reg  <= power_ind_next;
            attn_ind_reg   <= attn_ind_next;
            bus_conn_reg   <= bus_conn_next;
            clk_conn_reg   <= clk_conn_next;
            slot_reset_reg <= slot_reset_next;
            pind_out_reg   <= pind_out_next;
            aind_out_reg   <= aind_out_next;
        end
    end

    assign o_power_indicator_drive     = pind_out_reg;
    assign o_attention_indicator_drive = aind_out_reg;
    assign o_bus_connect_enable        = bus_conn_reg;
    assign o_clock_connect_enable      = clk_conn_reg;
    assign o_slot_reset_out            = slot_reset_reg;

endmodule

// ==== hdl/test_mode_and_poweron_control.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Power-good rise, select low: latch straps, normal.
// - Powered normal: drive serial data on strap pins.
// - Power-good rise, select high: straps pick test.
// - Select raised after power-good: run-time test.
// - Run-time: power indicator mirrors slot power enable.
// - Run-time: attention indicator mirrors ANDed slot fault.
// - NAND tree: all pins inputs except serial-in.
// - NAND tree: chain NAND drives serial-in output.
// - Initialise only on power-good low-to-high.
// - Initial slot outputs: indicators, enables 1, reset 0.
// - Report latched straps in diagnostic word bits.
module test_mode_and_poweron_control (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_power_good_in,
    input  wire logic        i_diag_select,
    input  wire logic        i_strap_upper_bit,
    input  wire logic        i_strap_lower_bit,
    input  wire logic        i_serial_out_data,
    input  wire logic        i_serial_in_data,
    input  wire logic [32:0] i_nand_chain,
    input  wire logic [1:0]  i_slot_load,
    input  wire logic [1:0]  i_power_ind_ctrl,
    input  wire logic [1:0]  i_attn_ind_ctrl,
    input  wire logic [1:0]  i_bus_conn_ctrl,
    input  wire logic [1:0]  i_clk_conn_ctrl,
    input  wire logic [1:0]  i_slot_reset_ctrl,
    input  wire logic [1:0]  i_slot_power_enable,
    input  wire logic [1:0]  i_slot_main_fault,
    input  wire logic [1:0]  i_slot_aux_fault,
    output logic             o_serial_out_data_out,
    output logic             o_serial_out_oe,
    output logic             o_serial_in_data_out,
    output logic             o_serial_in_oe,
    output logic             o_pins_oe,
    output logic [2:0]       o_mode,
    output logic [15:0]      o_diag_word,
    output logic [1:0]       o_power_indicator_drive,
    output logic [1:0]       o_attention_indicator_drive,
    output logic [1:0]       o_bus_connect_enable,
    output logic [1:0]       o_clock_connect_enable,
    output logic [1:0]       o_slot_reset_out
);

    test_mode_pkg::mode_state_t state_reg;
    test_mode_pkg::mode_state_t state_next;
    logic                       pg_prev_reg;
    logic                       sel_prev_reg;
    logic [1:0]                 strap_reg;
    logic [1:0]                 strap_next;
    logic                       so_reg;
    logic                       so_next;
    logic                       si_reg;
    logic                       si_next;
    logic                       pg_rise;
    logic                       sel_rise;
    logic [15:0]                diag;

    assign pg_rise  = i_power_good_in & ~pg_prev_reg;
    assign sel_rise = i_diag_select & ~sel_prev_reg;

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        strap_next = strap_reg;
        if (!i_power_good_in) begin
            state_next = test_mode_pkg::ST_UNPOWERED;
        end else if (pg_rise) begin
            if (!i_diag_select) begin
                state_next = test_mode_pkg::ST_NORMAL;
                strap_next = {i_strap_upper_bit, i_strap_lower_bit};
            end else if (i_strap_upper_bit) begin
                state_next = test_mode_pkg::ST_RESERVED;
            end else if (i_strap_lower_bit) begin
                state_next = test_mode_pkg::ST_TRISTATE;
            end else begin
                state_next = test_mode_pkg::ST_NAND_TREE;
            end
        end else begin
            // Test modes picked at the rise stay put whatever the straps do.
            case (state_reg)
                test_mode_pkg::ST_NORMAL: begin
                    if (sel_rise) begin
                        state_next = test_mode_pkg::ST_RUNTIME;
                    end
                end
                test_mode_pkg::ST_RUNTIME: begin
                    if (!i_diag_select) begin
                        state_next = test_mode_pkg::ST_NORMAL;
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strap pin data
    // ------------------------------------------------------------
    always_comb begin
        so_next = 1'h0;
        si_next = 1'h0;
        case (state_next)
            test_mode_pkg::ST_NORMAL, test_mode_pkg::ST_RUNTIME: begin
                so_next = i_serial_out_data;
                si_next = i_serial_in_data;
            end
            test_mode_pkg::ST_NAND_TREE: begin
                // Registered for a clean pin; the tester must wait a cycle per step.
                si_next = ~(&i_nand_chain);
            end
            default: begin
                so_next = 1'h0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg    <= test_mode_pkg::ST_UNPOWERED;
            pg_prev_reg  <= 1'h0;
            sel_prev_reg <= 1'h0;
            strap_reg    <= 2'h0;
            so_reg       <= 1'h0;
            si_reg       <= 1'h0;
        end else begin
            state_reg    <= state_next;
            pg_prev_reg  <= i_power_good_in;
            sel_prev_reg <= i_diag_select;
            strap_reg    <= strap_next;
            so_reg       <= so_next;
            si_reg       <= si_next;
        end
    end

    // ------------------------------------------------------------
    // Pin enables and reporting
    // ------------------------------------------------------------
    always_comb begin
        o_serial_out_oe = 1'h0;
        o_serial_in_oe  = 1'h0;
        o_pins_oe       = 1'h0;
        case (state_reg)
            test_mode_pkg::ST_NORMAL, test_mode_pkg::ST_RUNTIME: begin
                o_serial_out_oe = 1'h1;
                o_serial_in_oe  = 1'h1;
                o_pins_oe       = 1'h1;
            end
            test_mode_pkg::ST_NAND_TREE: begin
                o_serial_in_oe = 1'h1;
            end
            default: begin
                o_pins_oe = 1'h0;
            end
        endcase
    end

    always_comb begin
        diag = 16'h0000;
        diag[test_mode_pkg::DIAG_A_LOWER_POS] = strap_reg[0];
        diag[test_mode_pkg::DIAG_A_UPPER_POS] = strap_reg[1];
        diag[test_mode_pkg::DIAG_A_ONE_POS]   = 1'h1;
        diag[test_mode_pkg::DIAG_B_LOWER_POS] = strap_reg[0];
        diag[test_mode_pkg::DIAG_B_UPPER_POS] = strap_reg[1];
        diag[test_mode_pkg::DIAG_B_ONE_POS]   = 1'h1;
    end

    assign o_diag_word           = diag;
    assign o_mode                = state_reg;
    assign o_serial_out_data_out = so_reg;
    assign o_serial_in_data_out  = si_reg;

    // ------------------------------------------------------------
    // Slot outputs
    // ------------------------------------------------------------
    for (genvar s = 0; s < test_mode_pkg::NUM_SLOTS; s++) begin : g_slot
        slot_output_ctrl u_slot (
            .i_clk                       (i_clk),
            .i_rst_n                     (i_rst_n),
            .i_init                      (pg_rise),
            .i_load                      (i_slot_load[s]),
            .i_runtime                   (state_next == test_mode_pkg::ST_RUNTIME),
            .i_power_ind                 (i_power_ind_ctrl[s]),
            .i_attn_ind                  (i_attn_ind_ctrl[s]),
            .i_bus_conn                  (i_bus_conn_ctrl[s]),
            .i_clk_conn                  (i_clk_conn_ctrl[s]),
            .i_slot_reset                (i_slot_reset_ctrl[s]),
            .i_power_enable              (i_slot_power_enable[s]),
            .i_main_fault                (i_slot_main_fault[s]),
            .i_aux_fault                 (i_slot_aux_fault[s]),
            .o_power_indicator_drive     (o_power_indicator_drive[s]),
            .o_attention_indicator_drive (o_attention_indicator_drive[s]),
            .o_bus_connect_enable        (o_bus_connect_enable[s]),
            .o_clock_connect_enable      (o_clock_connect_enable[s]),
            .o_slot_reset_out            (o_slot_reset_out[s])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_normal_strap_latch: assert property (
        pg_rise && !i_diag_select |=> state_reg == test_mode_pkg::ST_NORMAL
            && strap_reg == $past({i_strap_upper_bit, i_strap_lower_bit}))
        else $error("Straps not latched into normal mode.");
    a_normal_pin_drive: assert property (
        state_reg == test_mode_pkg::ST_NORMAL || state_reg == test_mode_pkg::ST_RUNTIME |->
            o_serial_out_oe && o_serial_in_oe
            && o_serial_out_data_out == $past(i_serial_out_data)
            && o_serial_in_data_out == $past(i_serial_in_data))
        else $error("Strap pins not driven in normal mode.");
    a_test_mode_pick: assert property (
        pg_rise && i_diag_select && !i_strap_upper_bit |=>
            state_reg == ($past(i_strap_lower_bit) ? test_mode_pkg::ST_TRISTATE
                                                   : test_mode_pkg::ST_NAND_TREE))
        else $error("Wrong test mode picked.");
    a_runtime_entry: assert property (
        state_reg == test_mode_pkg::ST_NORMAL && sel_rise && i_power_good_in && !pg_rise
            |=> state_reg == test_mode_pkg::ST_RUNTIME)
        else $error("Run-time test not entered.");
    a_runtime_power_ind: assert property (
        state_next == test_mode_pkg::ST_RUNTIME |=>
            o_power_indicator_drive == $past(i_slot_power_enable))
        else $error("Power indicator not mirroring power enable.");
    a_runtime_attn_ind: assert property (
        state_next == test_mode_pkg::ST_RUNTIME |=>
            o_attention_indicator_drive == $past(i_slot_main_fault & i_slot_aux_fault))
        else $error("Attention indicator not mirroring fault.");
    a_nand_pin_float: assert property (
        state_reg == test_mode_pkg::ST_NAND_TREE |-> !o_serial_out_oe && !o_pins_oe
            && o_serial_in_oe)
        else $error("Pin enables wrong in NAND tree mode.");
    a_nand_result: assert property (
        state_reg == test_mode_pkg::ST_NAND_TREE && $stable(state_reg) |->
            o_serial_in_data_out == ~(&$past(i_nand_chain)))
        else $error("NAND tree result wrong.");
    a_init_levels: assert property (
        pg_rise |=> o_power_indicator_drive == 2'h3 && o_attention_indicator_drive == 2'h3
            && o_bus_connect_enable == 2'h3 && o_clock_connect_enable == 2'h3
            && o_slot_reset_out == 2'h0)
        else $error("Power-on slot levels wrong.");
    a_diag_report: assert property (
        o_diag_word == {5'h00, 1'h1, strap_reg, 5'h00, 1'h1, strap_reg})
        else $error("Diagnostic word mismatch.");
    a_test_mode_hold: assert property (
        (state_reg == test_mode_pkg::ST_NAND_TREE || state_reg == test_mode_pkg::ST_TRISTATE
            || state_reg == test_mode_pkg::ST_RESERVED) && i_power_good_in |=>
            state_reg == $past(state_reg))
        else $error("Test mode left without power cycle.");
    a_init_only_rise: assert property (
        !pg_rise && i_power_good_in |=> $stable(strap_reg))
        else $error("Straps changed without power-good rise.");

endmodule

// ==== testbench/board_tester.sv ====
`timescale 1ns/1ps

module board_tester (
    input  wire logic   i_clk,
    output logic        o_power_good,
    output logic        o_diag_select,
    output logic        o_strap_upper,
    output logic        o_strap_lower,
    output logic [32:0] o_nand_chain
);

    initial begin
        o_power_good  = 1'h0;
        o_diag_select = 1'h0;
        o_strap_upper = 1'h0;
        o_strap_lower = 1'h0;
        o_nand_chain  = {33{1'b1}};
    end

    // ------------------------------------------------------------
    // Supervisor
    // ------------------------------------------------------------
    // Power-good drops for two edges first, so every call gives a clean rise.
    task automatic power_cycle(input logic sel, input logic up, input logic lo);
        @(posedge i_clk);
        #1;
        o_power_good = 1'h0;
        repeat (2) @(posedge i_clk);
        #1;
        o_diag_select = sel;
        o_strap_upper = up;
        o_strap_lower = lo;
        o_nand_chain  = {33{1'b1}};
        o_power_good  = 1'h1;
    endtask

    task automatic set_select(input logic sel);
        o_diag_select = sel;
    endtask

    task automatic set_straps(input logic up, input logic lo);
        o_strap_upper = up;
        o_strap_lower = lo;
    endtask

    // ------------------------------------------------------------
    // Chain tester
    // ------------------------------------------------------------
    // The last position is the select pin itself, so the select follows it.
    task automatic nand_touch(input int idx, input int phase);
        @(posedge i_clk);
        #1;
        if (idx == 32) begin
            o_nand_chain[idx] = (phase == 0);
            o_diag_select     = (phase == 0);
        end else begin
            o_nand_chain[idx] = (phase == 1);
        end
    endtask

endmodule

// ==== testbench/tb_test_mode_and_poweron_control.sv ====
`timescale 1ns/1ps

module tb_test_mode_and_poweron_control;

    logic        clk;
    logic        rst_n;
    logic        pg;
    logic        sel;
    logic        up_t;
    logic        lo_t;
    logic        up_w;
    logic        lo_w;
    logic        sod;
    logic        sid;
    logic [32:0] chain;
    logic [1:0]  load;
    logic [1:0]  pic;
    logic [1:0]  aic;
    logic [1:0]  bcc;
    logic [1:0]  ccc;
    logic [1:0]  src;
    logic [1:0]  pe;
    logic [1:0]  mf;
    logic [1:0]  af;
    logic        sod_o;
    logic        so_oe;
    logic        sid_o;
    logic        si_oe;
    logic        pins_oe;
    logic [2:0]  mode;
    logic [15:0] diag;
    logic [1:0]  pwr;
    logic [1:0]  att;
    logic [1:0]  bus;
    logic [1:0]  cke;
    logic [1:0]  srst;
    int          errors;
    int          samples_checked;

    // The design wins the shared pins whenever it enables them.
    assign up_w = so_oe ? sod_o : up_t;
    assign lo_w = si_oe ? sid_o : lo_t;

    board_tester u_board_tester (
        .i_clk         (clk),
        .o_power_good  (pg),
        .o_diag_select (sel),
        .o_strap_upper (up_t),
        .o_strap_lower (lo_t),
        .o_nand_chain  (chain)
    );

    test_mode_and_poweron_control u_test_mode_and_poweron_control (
        .i_clk (clk), .i_rst_n (rst_n), .i_power_good_in (pg), .i_diag_select (sel),
        .i_strap_upper_bit (up_w), .i_strap_lower_bit (lo_w),
        .i_serial_out_data (sod), .i_serial_in_data (sid), .i_nand_chain (chain),
        .i_slot_load (load), .i_power_ind_ctrl (pic), .i_attn_ind_ctrl (aic),
        .i_bus_conn_ctrl (bcc), .i_clk_conn_ctrl (ccc), .i_slot_reset_ctrl (src),
        .i_slot_power_enable (pe), .i_slot_main_fault (mf), .i_slot_aux_fault (af),
        .o_serial_out_data_out (sod_o), .o_serial_out_oe (so_oe),
        .o_serial_in_data_out (sid_o), .o_serial_in_oe (si_oe), .o_pins_oe (pins_oe),
        .o_mode (mode), .o_diag_word (diag), .o_power_indicator_drive (pwr),
        .o_attention_indicator_drive (att), .o_bus_connect_enable (bus),
        .o_clock_connect_enable (cke), .o_slot_reset_out (srst)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_normal;
        for (int k = 0; k < 4; k++) begin
            u_board_tester.power_cycle(1'b0, k[1], k[0]);
            tick(2);
            check("mode", 16'(3'h1), 16'(mode));
            check("diag", {5'h00, 1'b1, k[1], k[0], 5'h00, 1'b1, k[1], k[0]}, diag);
            check("pin enables", 16'(3'h7), 16'({so_oe, si_oe, pins_oe}));
            check("slot init", 16'h03FC, 16'({pwr, att, bus, cke, srst}));
            sod = k[0];
            sid = ~k[0];
            tick(2);
            check("serial pins", 16'({k[0], ~k[0]}), 16'({sod_o, sid_o}));
            check("diag held", {5'h00, 1'b1, k[1], k[0], 5'h00, 1'b1, k[1], k[0]}, diag);
        end
    endtask

    task automatic test_slots;
        u_board_tester.power_cycle(1'b0, 1'b0, 1'b0);
        tick(2);
        pic  = 2'h2;
        aic  = 2'h1;
        bcc  = 2'h0;
        ccc  = 2'h2;
        src  = 2'h3;
        load = 2'h3;
        tick(1);
        load = 2'h0;
        tick(1);
        check("slot load", 16'h024B, 16'({pwr, att, bus, cke, srst}));
        u_board_tester.set_select(1'b1);
        tick(2);
        check("mode", 16'(3'h2), 16'(mode));
        for (int k = 0; k < 16; k++) begin
            mf = k[3:2];
            af = k[1:0];
            pe = k[2:1];
            tick(2);
            check("power indicator", 16'(k[2:1]), 16'(pwr));
            check("attention indicator", 16'(k[3:2] & k[1:0]), 16'(att));
        end
        u_board_tester.set_select(1'b0);
        tick(2);
        check("mode", 16'(3'h1), 16'(mode));
        check("slot after test", 16'h024B, 16'({pwr, att, bus, cke, srst}));
        u_board_tester.power_cycle(1'b0, 1'b0, 1'b0);
        tick(2);
        check("slot reinit", 16'h03FC, 16'({pwr, att, bus, cke, srst}));
    endtask

    task automatic test_nand;
        u_board_tester.power_cycle(1'b1, 1'b0, 1'b0);
        tick(2);
        check("mode", 16'(3'h3), 16'(mode));
        check("pin enables", 16'(3'h2), 16'({so_oe, si_oe, pins_oe}));
        for (int idx = 0; idx < 33; idx++) begin
            for (int ph = 0; ph < 2; ph++) begin
                u_board_tester.nand_touch(idx, ph);
                tick(2);
                check("nand out", 16'((idx == 32) ? (ph == 1) : (ph == 0)), 16'(sid_o));
            end
        end
        u_board_tester.set_straps(1'b0, 1'b1);
        tick(2);
        check("mode held", 16'(3'h3), 16'(mode));
    endtask

    task automatic test_tristate;
        for (int k = 0; k < 3; k++) begin
            u_board_tester.power_cycle(1'b1, k != 0, k != 1);
            tick(2);
            check("mode", (k == 0) ? 16'h0004 : 16'h0005, 16'(mode));
            check("pin enables", 16'h0000, 16'({so_oe, si_oe, pins_oe}));
            u_board_tester.set_straps(1'b0, 1'b0);
            tick(2);
            check("mode held", (k == 0) ? 16'h0004 : 16'h0005, 16'(mode));
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        errors          = 0;
        samples_checked = 0;
        rst_n           = 1'b0;
        {sod, sid, load, pic, aic, bcc, ccc, src, pe, mf, af} = '0;
        repeat (6) @(posedge clk);
        #1;
        check("mode in reset", 16'(3'h0), 16'(mode));
        check("diag in reset", 16'h0404, diag);
        rst_n = 1'b1;
        test_normal;
        test_slots;
        test_nand;
        test_tristate;
        report_and_stop;
    end

    // The whole run needs about 310 cycles; this leaves ample slack.
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end

endmodule
